//--- logic/dhc_pkg.sv
package dhc_pkg;
	// Register byte offsets on the slave port
	localparam logic [3:0] DHC_OFS_CTL = 4'h0;
	localparam logic [3:0] DHC_OFS_IRQ_STAT = 4'h4;
	localparam logic [3:0] DHC_OFS_IRQ_MASK = 4'h8;
	localparam int DHC_ADDR_W = 4;
	localparam int DHC_DATA_W = 32;

	// Field positions in debug_control
	localparam int DHC_CTL_HALT = 7;
	localparam int DHC_CTL_BREAKPOINT_ENABLE = 6;
	localparam int DHC_CTL_ACKEN = 5;
	localparam int DHC_CTL_RSVD_HI = 4;
	localparam int DHC_CTL_RSVD_LO = 1;
	localparam int DHC_CTL_SELFRST = 0;
	localparam logic [7:0] DHC_CTL_RESET = 8'h00;

	// Interrupt status and mask layout
	localparam int DHC_IRQ_W = 2;
	localparam int DHC_IRQ_BRK = 0;
	localparam int DHC_IRQ_RSTDONE = 1;
	localparam logic [DHC_IRQ_W-1:0] DHC_IRQ_RESET = 2'h0;

	// Acknowledge byte sent to the debug host on a breakpoint halt
	localparam logic [7:0] DHC_ACK_BYTE = 8'hff;

	// Length of the self-initiated core reset, in system clock cycles
	localparam int unsigned DHC_RST_CYCLES_DEF = 64;
	localparam int unsigned DHC_RST_CYCLES_MIN = 8;
	localparam int unsigned DHC_RST_CYCLES_MAX = 65535;
	localparam int DHC_RST_CNT_W = 16;
endpackage

//--- logic/dhc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module dhc_sync import dhc_pkg::*; #(
	parameter int WIDTH = 1
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] sync_ff;

	// Two stages; only the second stage is visible to the rest of the block
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			meta_ff <= '0;
			sync_ff <= '0;
		end else begin
			meta_ff <= async_in;
			sync_ff <= meta_ff;
		end
	end

	assign sync_out = sync_ff;
endmodule
`default_nettype wire

//--- logic/dhc_rst_seq.sv
`timescale 1ns/1ps
`default_nettype none
module dhc_rst_seq import dhc_pkg::*; #(
	parameter int unsigned CYCLES = DHC_RST_CYCLES_DEF
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic start,
	output logic busy,
	output logic done
);
	localparam logic [DHC_RST_CNT_W-1:0] LAST = DHC_RST_CNT_W'(CYCLES - 1);

	// A zero or oversized length would wrap the counter
	if (CYCLES < 1 || CYCLES > DHC_RST_CYCLES_MAX) begin : g_bad_cycles
		$error("CYCLES out of range");
	end

	logic busy_ff;
	logic [DHC_RST_CNT_W-1:0] cnt_ff;
	wire at_end = busy_ff & (cnt_ff == LAST);

	// Holds busy for exactly CYCLES clocks; a start while busy is ignored
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			busy_ff <= 1'b0;
			cnt_ff <= '0;
		end else begin
			if (at_end) begin
				busy_ff <= 1'b0;
			end else if (start & ~busy_ff) begin
				busy_ff <= 1'b1;
			end
			cnt_ff <= busy_ff ? cnt_ff + 1'b1 : '0;
		end
	end

	// Done marks the last busy cycle, so a flag cleared by it falls on the same edge as busy
	assign busy = busy_ff;
	assign done = at_end;
endmodule
`default_nettype wire

//--- logic/dhc_debug_ctl.sv
`timescale 1ns/1ps
`default_nettype none
// Operation
// [R1] Writing one to the halt bit puts the device into debug state.
// [R2] In debug state the core fetches nothing and idles until released.
// [R3] Writing zero to the halt bit lets the core resume execution.
// [R4] Halt bit sets itself when a breakpoint opcode decodes with breakpoints enabled.
// [R5] With read protection active, zero writes to halt are ignored; reset only clears.
// [R6] Halt bit reads one in debug state and zero in normal running.
// [R7] Bits four down to one of the control register always read zero.
// [R8] Writing one to self-reset resets the device but spares the debugger.
// [R9] Self-reset bit returns to zero once its reset has completed.
// [R10] With breakpoints disabled the breakpoint signal is ignored, opcode acts as no-op.
// [R11] Enabled breakpoint signal from the core enters debug state and idles core.
// [R12] With acknowledge enabled, a breakpoint halt sends one all-ones byte to host.
// [R13] Breakpoint enable resets to zero, so breakpoints start disabled.
module dhc_debug_ctl import dhc_pkg::*; #(
	parameter int unsigned RST_CYCLES = DHC_RST_CYCLES_DEF
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic [DHC_ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [DHC_DATA_W-1:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [DHC_DATA_W-1:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic core_brk_decoded,
	output logic core_halt,
	output logic core_reset,
	input wire logic read_protect_option,
	output logic ack_valid,
	output logic [7:0] ack_data,
	input wire logic ack_ready,
	output logic irq
);
	// Refuse sequence lengths the counter or the checks cannot serve
	if (RST_CYCLES < DHC_RST_CYCLES_MIN || RST_CYCLES > DHC_RST_CYCLES_MAX) begin : g_bad_len
		$error("RST_CYCLES out of range");
	end

	logic wait_ff;
	logic [DHC_DATA_W-1:0] rdata_ff;
	logic halt_ff;
	logic breakpoint_enable_ff;
	logic acken_ff;
	logic selfrst_ff;
	logic ack_valid_ff;
	logic [DHC_IRQ_W-1:0] stat_ff;
	logic [DHC_IRQ_W-1:0] mask_ff;
	logic irq_ff;
	logic rp_sync;
	logic seq_busy;
	logic seq_done;

	// Read protection arrives from the option pins, outside this clock
	dhc_sync #(
		.WIDTH(1)
	) u_rp_sync (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.async_in(read_protect_option),
		.sync_out(rp_sync)
	);

	// Address decode and transfer acceptance
	wire req = avs_read | avs_write;
	wire sel_ctl = (avs_address == DHC_OFS_CTL);
	wire sel_stat = (avs_address == DHC_OFS_IRQ_STAT);
	wire sel_mask = (avs_address == DHC_OFS_IRQ_MASK);
	wire acc_wr = avs_write & ~wait_ff;
	wire lane0 = avs_byteenable[0];
	wire ctl_wr = acc_wr & sel_ctl & lane0;
	wire stat_wr = acc_wr & sel_stat & lane0;
	wire mask_wr = acc_wr & sel_mask & lane0;
	wire [7:0] wbyte = avs_writedata[7:0];

	// Control register image; reserved field is hard zero
	wire [7:0] ctl_image = {halt_ff, breakpoint_enable_ff, acken_ff, 4'h0, selfrst_ff}; // [R6] [R7]

	// Read mux; unmapped offsets read as zero
	wire [DHC_DATA_W-1:0] rd_mux =
		sel_ctl ? {24'h0, ctl_image} :
		sel_stat ? {30'h0, stat_ff} :
		sel_mask ? {30'h0, mask_ff} : 32'h0;

	// Breakpoint qualification: only honoured with breakpoints enabled
	wire brk_hit = core_brk_decoded & breakpoint_enable_ff; // [R4] [R10] [R11]
	wire halt_set = brk_hit | (ctl_wr & wbyte[DHC_CTL_HALT]); // [R1]
	wire halt_clr = ctl_wr & ~wbyte[DHC_CTL_HALT] & ~rp_sync; // [R3] [R5]
	wire nxt_halt = halt_set | (halt_ff & ~halt_clr);

	// Self-reset start; a second one while running is ignored
	wire rst_start = ctl_wr & wbyte[DHC_CTL_SELFRST] & ~selfrst_ff; // [R8]

	// Acknowledge byte: a new halt wins over the host taking the old one
	wire ack_set = brk_hit & acken_ff; // [R12]
	wire nxt_ack_valid = ack_set | (ack_valid_ff & ~ack_ready);

	// Sticky events; a new event wins over a write-one-to-clear
	wire [DHC_IRQ_W-1:0] ev = {seq_done, brk_hit};
	wire [DHC_IRQ_W-1:0] w1c = stat_wr ? wbyte[DHC_IRQ_W-1:0] : '0;
	wire [DHC_IRQ_W-1:0] nxt_stat = ev | (stat_ff & ~w1c);

	// One-cycle wait state on every access: waitrequest drops on the second cycle
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			wait_ff <= 1'b1;
			rdata_ff <= '0;
		end else begin
			wait_ff <= ~(req & wait_ff);
			if (avs_read & wait_ff) begin
				rdata_ff <= rd_mux; // [R6]
			end
		end
	end

	// Halt state drives the core stall directly, so no fetch slips through
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			halt_ff <= DHC_CTL_RESET[DHC_CTL_HALT];
		end else begin
			halt_ff <= nxt_halt; // [R2]
		end
	end

	// Enable bits keep their value across a self-reset, as the debugger is spared
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			breakpoint_enable_ff <= DHC_CTL_RESET[DHC_CTL_BREAKPOINT_ENABLE]; // [R13]
			acken_ff <= DHC_CTL_RESET[DHC_CTL_ACKEN];
		end else if (ctl_wr) begin
			breakpoint_enable_ff <= wbyte[DHC_CTL_BREAKPOINT_ENABLE];
			acken_ff <= wbyte[DHC_CTL_ACKEN];
		end
	end

	// Self-reset bit stays high until the sequencer reports the end
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			selfrst_ff <= DHC_CTL_RESET[DHC_CTL_SELFRST];
		end else if (seq_done) begin
			selfrst_ff <= 1'b0; // [R9]
		end else if (rst_start) begin
			selfrst_ff <= 1'b1;
		end
	end

	// Core reset pulse generator; the debugger logic here is never reset by it
	dhc_rst_seq #(
		.CYCLES(RST_CYCLES)
	) u_rst_seq (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.start(rst_start),
		.busy(seq_busy),
		.done(seq_done)
	);

	// Acknowledge holding stage toward the serial transmitter
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			ack_valid_ff <= 1'b0;
		end else begin
			ack_valid_ff <= nxt_ack_valid; // [R12]
		end
	end

	// Interrupt status, mask and registered level output
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			stat_ff <= DHC_IRQ_RESET;
			mask_ff <= DHC_IRQ_RESET;
			irq_ff <= 1'b0;
		end else begin
			stat_ff <= nxt_stat;
			if (mask_wr) begin
				mask_ff <= wbyte[DHC_IRQ_W-1:0];
			end
			irq_ff <= |(nxt_stat & (mask_wr ? wbyte[DHC_IRQ_W-1:0] : mask_ff));
		end
	end

	// Outputs straight from flops, except ack_data, which is the constant DHC_ACK_BYTE
	assign avs_waitrequest = wait_ff;
	assign avs_readdata = rdata_ff;
	assign core_halt = halt_ff;
	assign core_reset = seq_busy;
	assign ack_valid = ack_valid_ff;
	assign ack_data = DHC_ACK_BYTE;
	assign irq = irq_ff;

	// Checks kept beside the logic they guard
	sequence s_halt_write;
		ctl_wr && wbyte[DHC_CTL_HALT];
	endsequence

	sequence s_brk_taken;
		core_brk_decoded && breakpoint_enable_ff;
	endsequence

	sequence s_ctl_read_req;
		avs_read && wait_ff && sel_ctl;
	endsequence

	sequence s_ack_taken;
		ack_valid && ack_ready;
	endsequence

	AST_HALT_ON_WRITE: assert property (@(posedge ref_clk) disable iff (!resetn) // [R1]
		s_halt_write |=> core_halt)
		else $error("halt bit write did not stall the core");

	AST_HALT_HOLDS: assert property (@(posedge ref_clk) disable iff (!resetn) // [R2]
		(core_halt && !ctl_wr) |=> core_halt)
		else $error("core left debug state without a control write");

	AST_RESUME: assert property (@(posedge ref_clk) disable iff (!resetn) // [R3]
		(core_halt && ctl_wr && !wbyte[DHC_CTL_HALT] && !rp_sync && !core_brk_decoded) |=> !core_halt)
		else $error("clearing the halt bit did not resume the core");

	AST_BRK_HALTS: assert property (@(posedge ref_clk) disable iff (!resetn) // [R4]
		s_brk_taken |=> core_halt ##0 $past(breakpoint_enable_ff))
		else $error("enabled breakpoint did not halt the core");

	AST_PROTECT_HOLD: assert property (@(posedge ref_clk) disable iff (!resetn) // [R5]
		(rp_sync && core_halt) |=> core_halt)
		else $error("halt bit cleared while read protection active");

	AST_READ_HALT: assert property (@(posedge ref_clk) disable iff (!resetn) // [R6]
		s_ctl_read_req |=> (!avs_waitrequest && avs_readdata[DHC_CTL_HALT] == $past(core_halt)))
		else $error("halt bit read back wrong");

	AST_RSVD_ZERO: assert property (@(posedge ref_clk) disable iff (!resetn) // [R7]
		s_ctl_read_req |=> (avs_readdata[DHC_CTL_RSVD_HI:DHC_CTL_RSVD_LO] == 4'h0 && avs_readdata[31:8] == 24'h0))
		else $error("reserved control bits read nonzero");

	AST_SELF_RESET: assert property (@(posedge ref_clk) disable iff (!resetn) // [R8]
		rst_start |=> (core_reset && selfrst_ff) [*8])
		else $error("self-reset did not hold the core in reset");

	AST_RST_BIT_CLEAR: assert property (@(posedge ref_clk) disable iff (!resetn) // [R9]
		$fell(core_reset) |-> (!selfrst_ff && stat_ff[DHC_IRQ_RSTDONE]))
		else $error("self-reset bit not cleared at end of reset");

	AST_BRK_IGNORED: assert property (@(posedge ref_clk) disable iff (!resetn) // [R10]
		(core_brk_decoded && !breakpoint_enable_ff && !core_halt && !ctl_wr) |=>
		(!core_halt && !$rose(ack_valid) && !$rose(stat_ff[DHC_IRQ_BRK])))
		else $error("disabled breakpoint was not ignored");

	AST_BRK_ENTERS: assert property (@(posedge ref_clk) disable iff (!resetn) // [R11]
		s_brk_taken |=> (core_halt && stat_ff[DHC_IRQ_BRK]))
		else $error("breakpoint event not recorded with halt");

	AST_ACK_SENT: assert property (@(posedge ref_clk) disable iff (!resetn) // [R12]
		(s_brk_taken ##0 acken_ff) |=> (ack_valid && ack_data == 8'hff))
		else $error("acknowledge byte not offered after breakpoint halt");

	AST_ACK_QUIET: assert property (@(posedge ref_clk) disable iff (!resetn) // [R12]
		(!acken_ff && !ack_valid) |=> !ack_valid)
		else $error("acknowledge offered while acknowledge disabled");

	AST_BREAKPOINT_ENABLE_RESET: assert property (@(posedge ref_clk) disable iff (!resetn) // [R13]
		$rose(resetn) |-> (!breakpoint_enable_ff && !core_halt))
		else $error("breakpoint enable not clear after reset");

	// Bus timing: exactly one wait state, and never two accept cycles in a row
	AST_WAIT_ONE: assert property (@(posedge ref_clk) disable iff (!resetn)
		(req && avs_waitrequest) |=> !avs_waitrequest)
		else $error("request not answered after one wait state");

	AST_WAIT_BACK: assert property (@(posedge ref_clk) disable iff (!resetn)
		!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");

	// Acknowledge handshake: offered until taken, gone after taking unless a new halt arrives
	AST_ACK_HOLD: assert property (@(posedge ref_clk) disable iff (!resetn) // [R12]
		(ack_valid && !ack_ready) |=> ack_valid)
		else $error("acknowledge withdrawn before the host took it");

	AST_ACK_DONE: assert property (@(posedge ref_clk) disable iff (!resetn) // [R12]
		(s_ack_taken ##0 !(brk_hit && acken_ff)) |=> !ack_valid)
		else $error("acknowledge still offered after the host took it");

	// Self-reset bit and core reset must span the same cycles
	AST_RST_TRACK: assert property (@(posedge ref_clk) disable iff (!resetn) // [R9]
		selfrst_ff == core_reset)
		else $error("self-reset bit and core reset disagree");

	AST_ZERO_NO_RESET: assert property (@(posedge ref_clk) disable iff (!resetn) // [R8]
		(ctl_wr && !wbyte[DHC_CTL_SELFRST] && !core_reset) |=> !core_reset)
		else $error("zero write to self-reset started a core reset");

	AST_HALT_SPARED: assert property (@(posedge ref_clk) disable iff (!resetn) // [R8]
		(core_reset && !ctl_wr && !brk_hit) |=> $stable(core_halt))
		else $error("self-reset disturbed the debug state");

	// Interrupt level is the registered image of status and mask
	AST_IRQ_LEVEL: assert property (@(posedge ref_clk) disable iff (!resetn)
		irq == |(stat_ff & mask_ff))
		else $error("interrupt level disagrees with status and mask");

	AST_STAT_STICKY: assert property (@(posedge ref_clk) disable iff (!resetn)
		(stat_ff[DHC_IRQ_BRK] && !(stat_wr && wbyte[DHC_IRQ_BRK])) |=> stat_ff[DHC_IRQ_BRK])
		else $error("breakpoint status cleared without a one write");
endmodule
`default_nettype wire

//--- verif/dhc_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module dhc_core_model (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic brk_req,
	input wire logic core_halt,
	input wire logic core_reset,
	output logic core_brk_decoded,
	output logic [15:0] fetch_ff
);
	// A halted or resetting core fetches nothing, so it cannot decode a breakpoint either
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			fetch_ff <= 16'h0000;
			core_brk_decoded <= 1'b0;
		end else begin
			if (!core_halt && !core_reset) fetch_ff <= fetch_ff + 16'h0001;
			core_brk_decoded <= brk_req && !core_halt && !core_reset;
		end
	end
endmodule
`default_nettype wire

//--- verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb import dhc_pkg::*;;
	localparam int unsigned RST = 8;
	logic ref_clk = 1'b0, resetn = 1'b0, avs_read = 1'b0, avs_write = 1'b0, ack_ready = 1'b0;
	logic brk_req = 1'b0, read_protect_option = 1'b0;
	logic avs_waitrequest, core_brk_decoded, core_halt, core_reset, ack_valid, irq;
	logic [3:0] avs_address = 4'h0;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, rng = 32'd23002;
	logic [7:0] ack_data;
	logic [15:0] fetch, f0;
	logic [31:0] exp_q[$];
	int err_total = 0, samples_checked = 0, cyc = 0, rst_hi = 0;
	initial forever #2 ref_clk = ~ref_clk;
	dhc_debug_ctl #(.RST_CYCLES(RST)) u_dut (.ref_clk(ref_clk), .resetn(resetn), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .core_brk_decoded(core_brk_decoded),
		.core_halt(core_halt), .core_reset(core_reset), .read_protect_option(read_protect_option),
		.ack_valid(ack_valid), .ack_data(ack_data), .ack_ready(ack_ready), .irq(irq));
	dhc_core_model u_core (.ref_clk(ref_clk), .resetn(resetn), .brk_req(brk_req), .core_halt(core_halt),
		.core_reset(core_reset), .core_brk_decoded(core_brk_decoded), .fetch_ff(fetch));
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic stop_test();
		$display("mismatches=%0d checks=%0d", err_total, samples_checked);
		if (err_total == 0 && samples_checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// Request held until the edge that samples waitrequest low, then one idle edge
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		@(posedge ref_clk);
		while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		bus(1'b0, a, 32'h0);
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task automatic breakpoint_opcode();
		brk_req <= 1'b1;
		@(posedge ref_clk);
		brk_req <= 1'b0;
		wt(3);
	endtask
	// Read data judged at the taking edge against the oldest note; also the hang limit
	always @(posedge ref_clk) begin
		cyc++;
		if (core_reset === 1'b1) rst_hi++;
		if (avs_read === 1'b1 && avs_waitrequest === 1'b0) cmp(avs_readdata, exp_q.pop_front());
		if (cyc > 20000) begin
			err_total++;
			stop_test();
		end
	end
	initial begin
		wt(3);
		resetn <= 1'b1;
		@(posedge ref_clk);
		rd(DHC_OFS_CTL, 32'h0);
		rd(4'hc, 32'h0);
		rd(DHC_OFS_IRQ_STAT, 32'h0);
		// Random control bytes; reserved bits must read zero, halt tracks bit 7
		for (int i = 0; i < 6; i++) begin
			rng = xs(rng);
			bus(1'b1, DHC_OFS_CTL, {24'h0, rng[7:1], 1'b0});
			rd(DHC_OFS_CTL, {24'h0, rng[7:5], 5'h00});
			cmp(core_halt, rng[7]);
			cmp(core_reset, 1'b0);
		end
		bus(1'b1, 4'hc, 32'hff);
		rd(DHC_OFS_CTL, {24'h0, rng[7:5], 5'h00});
		bus(1'b1, DHC_OFS_CTL, 32'h80);
		f0 = fetch;
		wt(10);
		cmp(fetch, f0);
		bus(1'b1, DHC_OFS_CTL, 32'h00);
		wt(4);
		cmp(fetch > f0, 1'b1);
		breakpoint_opcode();
		rd(DHC_OFS_CTL, 32'h0);
		rd(DHC_OFS_IRQ_STAT, 32'h0);
		bus(1'b1, DHC_OFS_IRQ_MASK, 32'h3);
		bus(1'b1, DHC_OFS_CTL, 32'h60);
		breakpoint_opcode();
		rd(DHC_OFS_CTL, 32'he0);
		cmp(ack_valid, 1'b1);
		cmp(ack_data, 8'hff);
		cmp(irq, 1'b1);
		rng = xs(rng);
		wt(rng[3:0]);
		ack_ready <= 1'b1;
		@(posedge ref_clk);
		ack_ready <= 1'b0;
		@(posedge ref_clk);
		cmp(ack_valid, 1'b0);
		rd(DHC_OFS_IRQ_STAT, 32'h1);
		bus(1'b1, DHC_OFS_IRQ_STAT, 32'h1);
		wt(2);
		cmp(irq, 1'b0);
		// Masked event: status sets, irq stays low until unmasked; no ack without enable
		bus(1'b1, DHC_OFS_IRQ_MASK, 32'h0);
		bus(1'b1, DHC_OFS_CTL, 32'h40);
		breakpoint_opcode();
		cmp(ack_valid, 1'b0);
		cmp(irq, 1'b0);
		rd(DHC_OFS_IRQ_STAT, 32'h1);
		bus(1'b1, DHC_OFS_IRQ_MASK, 32'h1);
		wt(2);
		cmp(irq, 1'b1);
		bus(1'b1, DHC_OFS_IRQ_STAT, 32'h1);
		wt(2);
		cmp(irq, 1'b0);
		// Protection: a zero write cannot release the core, only reset can
		read_protect_option <= 1'b1;
		wt(4);
		bus(1'b1, DHC_OFS_CTL, 32'h00);
		rd(DHC_OFS_CTL, 32'h80);
		cmp(core_halt, 1'b1);
		resetn <= 1'b0;
		wt(2);
		cmp(core_halt, 1'b0);
		cmp(avs_waitrequest, 1'b1);
		resetn <= 1'b1;
		read_protect_option <= 1'b0;
		wt(4);
		rd(DHC_OFS_CTL, 32'h0);
		bus(1'b1, DHC_OFS_IRQ_MASK, 32'h2);
		bus(1'b1, DHC_OFS_CTL, 32'h80);
		rst_hi = 0;
		bus(1'b1, DHC_OFS_CTL, 32'h81);
		rd(DHC_OFS_CTL, 32'h81);
		cmp(core_reset, 1'b1);
		wt(RST + 2);
		cmp(rst_hi, RST);
		rd(DHC_OFS_CTL, 32'h80);
		rd(DHC_OFS_IRQ_STAT, 32'h2);
		cmp(irq, 1'b1);
		stop_test();
	end
endmodule
`default_nettype wire
